// File: rtl/smp_defines.svh
// Purpose: named constants for the secure RAM partition controller
// Assumes: fixed sizes, one clock
// Notes:   header only, no logic
`ifndef SMP_DEFINES_SVH
`define SMP_DEFINES_SVH
// ---------------------------------------------------------------
// sizes
// ---------------------------------------------------------------
`define SMP_NPART   4
`define SMP_PTW     2
`define SMP_NPAGE   8
`define SMP_PGW     3
`define SMP_WDW     4
`define SMP_LAST_WD 4'hF
`define SMP_ZLEN    5'h10
`define SMP_ADDRW   7
`define SMP_NWORD   128
`define SMP_DW      32
`define SMP_MIDW    4
`define SMP_GRPW    16
// ---------------------------------------------------------------
// permission register fields
// ---------------------------------------------------------------
`define SMP_PERMW   5
`define SMP_P_CSP   3
`define SMP_P_PSP   4
// ---------------------------------------------------------------
// encodings
// ---------------------------------------------------------------
`define SMP_ST_IDLE 2'h0
`define SMP_ST_ZERO 2'h1
`define SMP_ST_DONE 2'h3
`define SMP_OP_PERM 3'h0
`define SMP_OP_GRP  3'h1
`define SMP_OP_ALOC 3'h2
`define SMP_OP_RPG  3'h3
`define SMP_OP_RPT  3'h4
`define SMP_K_RD    2'h0
`define SMP_K_WR    2'h1
`define SMP_K_FX    2'h2
`endif

// File: rtl/smp_pkg.sv
// Purpose: types for the secure RAM partition controller
// Assumes: smp_defines.svh gives the widths
// Notes:   none
`include "smp_defines.svh"
package smp_pkg;
  typedef enum logic [1:0] {SMP_IDLE = `SMP_ST_IDLE, SMP_ZERO = `SMP_ST_ZERO,
                            SMP_DONE = `SMP_ST_DONE} smp_zst_e;
  typedef enum logic [2:0] {SMP_PERM = `SMP_OP_PERM, SMP_GRP = `SMP_OP_GRP,
                            SMP_ALOC = `SMP_OP_ALOC, SMP_RPG = `SMP_OP_RPG,
                            SMP_RPT = `SMP_OP_RPT} smp_op_e;
  typedef enum logic [1:0] {SMP_RD = `SMP_K_RD, SMP_WR = `SMP_K_WR,
                            SMP_FX = `SMP_K_FX} smp_kind_e;
  typedef logic [`SMP_MIDW-1:0]  smp_mid_t;
  typedef logic [`SMP_PTW-1:0]   smp_pt_t;
  typedef logic [`SMP_PGW-1:0]   smp_pg_t;
  typedef logic [`SMP_WDW-1:0]   smp_wd_t;
  typedef logic [`SMP_ADDRW-1:0] smp_addr_t;
endpackage

// File: rtl/smp_ctrl.sv
// Purpose: ownership, access check and zeroization for partitioned secure_ram
// Assumes: one clock, requester holds acc_valid until acc_done
// Notes:   commands answer one cycle after they are taken
// How it works
// R1 - write to free partition permission claims it
// R2 - allocate command claims a free page
// R3 - only owner releases partition by command
// R4 - public marked partition release is refused
// R5 - violation zeroes all pages of critical partitions
// R6 - critical partition pages zeroed before rejoining pool
// R7 - released critical page is zeroed first
// R8 - every access checked against partition permissions
// R9 - only owner edits permission and group; owns pages
// R10 - page release refused in public partition
// R11 - page and partition state held internally
`timescale 1ns/1ps
`include "smp_defines.svh"
module smp_ctrl (
  input  wire logic                 core_clk,
  input  wire logic                 rst,
  input  wire logic                 violation_in,
  input  wire logic                 cmd_valid,
  input  wire smp_pkg::smp_op_e     cmd_op,
  input  wire smp_pkg::smp_mid_t    cmd_mid,
  input  wire smp_pkg::smp_pt_t     cmd_part,
  input  wire smp_pkg::smp_pg_t     cmd_page,
  input  wire logic [`SMP_GRPW-1:0] cmd_data,
  output logic                      cmd_done,
  output logic                      cmd_err,
  input  wire logic                 acc_valid,
  input  wire smp_pkg::smp_kind_e   acc_kind,
  input  wire smp_pkg::smp_mid_t    acc_mid,
  input  wire smp_pkg::smp_addr_t   acc_addr,
  input  wire logic [`SMP_DW-1:0]   acc_wdata,
  output logic                      acc_done,
  output logic                      acc_err,
  output logic [`SMP_DW-1:0]        acc_rdata,
  output logic                      zero_busy
);
  import smp_pkg::*;
  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  logic [`SMP_DW-1:0]    mem [`SMP_NWORD];       // secure_ram words
  logic [`SMP_NPART-1:0] pt_own_ff;              // partition claimed
  smp_mid_t              pt_owner_ff [`SMP_NPART];
  logic [`SMP_PERMW-1:0] pt_perm_ff [`SMP_NPART]; // partition_permission_reg
  logic [`SMP_GRPW-1:0]  pt_grp_ff [`SMP_NPART];  // partition_access_group_reg
  logic [`SMP_NPAGE-1:0] pg_alloc_ff;            // page claimed
  logic [`SMP_NPAGE-1:0] pg_pend_ff;             // page awaits zeroing
  logic [`SMP_NPAGE-1:0] pg_rel_ff;              // free page after zeroing
  smp_pt_t               pg_part_ff [`SMP_NPAGE];
  logic [`SMP_NPAGE-1:0] pg_csp;                 // page lies in critical partition
  smp_zst_e              zst_ff;
  smp_pg_t               zpg_ff;
  smp_wd_t               zwd_ff;
  logic [`SMP_WDW:0]     zlen_ff;                // cycles spent scrubbing this page
  logic                  vs1_ff, vs2_ff, vs3_ff; // violation sync and edge
  logic                  viol_rise;
  // ---------------------------------------------------------------
  // command decode
  // ---------------------------------------------------------------
  smp_pt_t cpg_pt;
  logic    is_owner, pg_mine, cmd_ok;
  logic    do_perm, do_grp, do_aloc, do_rpg, do_rpt;
  assign cpg_pt   = pg_part_ff[cmd_page];
  assign is_owner = pt_own_ff[cmd_part] && (pt_owner_ff[cmd_part] == cmd_mid);
  // a page in zeroing cannot be released on its own
  assign pg_mine  = pg_alloc_ff[cmd_page] && !pg_pend_ff[cmd_page] &&
                    pt_own_ff[cpg_pt] && (pt_owner_ff[cpg_pt] == cmd_mid); // [R9]
  // judge the request against ownership and marks
  always_comb
  begin
    cmd_ok = 1'b0;
    case (cmd_op)
      SMP_PERM: cmd_ok = !pt_own_ff[cmd_part] || is_owner;              // [R1] [R9]
      SMP_GRP:  cmd_ok = is_owner;                                      // [R9]
      SMP_ALOC: cmd_ok = is_owner && !pg_alloc_ff[cmd_page] &&
                         !pg_pend_ff[cmd_page];                          // [R2]
      SMP_RPG:  cmd_ok = pg_mine && !pt_perm_ff[cpg_pt][`SMP_P_PSP];     // [R10]
      SMP_RPT:  cmd_ok = is_owner && !pt_perm_ff[cmd_part][`SMP_P_PSP];  // [R3] [R4]
      default:  cmd_ok = 1'b0;
    endcase
  end
  assign do_perm = cmd_valid && cmd_ok && (cmd_op == SMP_PERM);
  assign do_grp  = cmd_valid && cmd_ok && (cmd_op == SMP_GRP);
  assign do_aloc = cmd_valid && cmd_ok && (cmd_op == SMP_ALOC);
  assign do_rpg  = cmd_valid && cmd_ok && (cmd_op == SMP_RPG);
  assign do_rpt  = cmd_valid && cmd_ok && (cmd_op == SMP_RPT);
  // command answer pulse
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      cmd_done <= 1'b0;
      cmd_err  <= 1'b0;
    end
    else
    begin
      cmd_done <= cmd_valid;
      cmd_err  <= cmd_valid && !cmd_ok;
    end
  end
  // ---------------------------------------------------------------
  // partition state
  // ---------------------------------------------------------------
  genvar gp, gg;
  generate
    for (gp = 0; gp < `SMP_NPART; gp++)
    begin : g_pt
      logic me;
      assign me = (cmd_part == smp_pt_t'(gp));
      // claim, edit or drop one partition
      always_ff @(posedge core_clk or posedge rst)
      begin
        if (rst)
        begin
          pt_own_ff[gp]   <= 1'b0;
          pt_owner_ff[gp] <= '0;
          pt_perm_ff[gp]  <= '0;
          pt_grp_ff[gp]   <= '0;
        end
        else if (do_perm && me)
        begin
          pt_own_ff[gp]   <= 1'b1;                                      // [R1]
          pt_owner_ff[gp] <= cmd_mid;
          pt_perm_ff[gp]  <= cmd_data[`SMP_PERMW-1:0];
        end
        else if (do_grp && me)
          pt_grp_ff[gp] <= cmd_data;                                    // [R9]
        else if (do_rpt && me)
        begin
          pt_own_ff[gp]  <= 1'b0;                                       // [R3]
          pt_perm_ff[gp] <= '0;
          pt_grp_ff[gp]  <= '0;
        end
      end
    end
    // ---------------------------------------------------------------
    // page state
    // ---------------------------------------------------------------
    for (gg = 0; gg < `SMP_NPAGE; gg++)
    begin : g_pg
      logic relme, zdone, zset;
      assign pg_csp[gg] = pt_perm_ff[pg_part_ff[gg]][`SMP_P_CSP];
      assign relme = (do_rpg && (cmd_page == smp_pg_t'(gg))) ||
                     (do_rpt && pg_alloc_ff[gg] && (pg_part_ff[gg] == cmd_part));
      assign zdone = (zst_ff == SMP_DONE) && (zpg_ff == smp_pg_t'(gg));
      assign zset  = (relme && pg_csp[gg]) ||
                     (viol_rise && pg_alloc_ff[gg] && pg_csp[gg]);       // [R5]
      // critical pages stay claimed until scrubbed
      always_ff @(posedge core_clk or posedge rst)
      begin
        if (rst)
        begin
          pg_alloc_ff[gg] <= 1'b0;
          pg_part_ff[gg]  <= '0;
        end
        else if (do_aloc && (cmd_page == smp_pg_t'(gg)))
        begin
          pg_alloc_ff[gg] <= 1'b1;                                      // [R2] [R11]
          pg_part_ff[gg]  <= cmd_part;
        end
        else if (relme && !pg_csp[gg])
          pg_alloc_ff[gg] <= 1'b0;
        else if (zdone && pg_rel_ff[gg])
          pg_alloc_ff[gg] <= 1'b0;                                      // [R6] [R7]
      end
      // zero request flags, a new request beats the clear
      always_ff @(posedge core_clk or posedge rst)
      begin
        if (rst)
        begin
          pg_pend_ff[gg] <= 1'b0;
          pg_rel_ff[gg]  <= 1'b0;
        end
        else
        begin
          if (zset)
            pg_pend_ff[gg] <= 1'b1;                                     // [R5] [R6] [R7]
          else if (zdone)
            pg_pend_ff[gg] <= 1'b0;
          if (relme && pg_csp[gg])
            pg_rel_ff[gg] <= 1'b1;
          else if (zdone)
            pg_rel_ff[gg] <= 1'b0;
        end
      end
    end
  endgenerate
  // ---------------------------------------------------------------
  // violation input, two stages then edge
  // ---------------------------------------------------------------
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      vs1_ff <= 1'b0;
      vs2_ff <= 1'b0;
      vs3_ff <= 1'b0;
    end
    else
    begin
      vs1_ff <= violation_in;
      vs2_ff <= vs1_ff;
      vs3_ff <= vs2_ff;
    end
  end
  assign viol_rise = vs2_ff && !vs3_ff;
  // ---------------------------------------------------------------
  // zeroizer: lowest pending page first, one word a cycle
  // ---------------------------------------------------------------
  function automatic smp_pg_t first_pg(input logic [`SMP_NPAGE-1:0] v);
    first_pg = '0;
    for (int i = `SMP_NPAGE - 1; i >= 0; i--)
      if (v[i])
        first_pg = smp_pg_t'(i);
  endfunction
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      zst_ff    <= SMP_IDLE;
      zpg_ff    <= '0;
      zwd_ff    <= '0;
      zero_busy <= 1'b0;
    end
    else
    begin
      zero_busy <= |pg_pend_ff;
      case (zst_ff)
        SMP_IDLE:
          if (|pg_pend_ff)
          begin
            zpg_ff <= first_pg(pg_pend_ff);
            zwd_ff <= '0;
            zst_ff <= SMP_ZERO;
          end
        SMP_ZERO:
        begin
          zwd_ff <= zwd_ff + 1'b1;
          if (zwd_ff == `SMP_LAST_WD)
            zst_ff <= SMP_DONE;
        end
        SMP_DONE: zst_ff <= SMP_IDLE;
        default:  zst_ff <= SMP_IDLE;
      endcase
    end
  end
  // ---------------------------------------------------------------
  // access check; stalls while the zeroizer owns the write port
  // ---------------------------------------------------------------
  smp_pg_t apg;
  smp_pt_t apt;
  logic    acc_take, acc_ok;
  assign apg      = acc_addr[`SMP_ADDRW-1:`SMP_WDW];
  assign apt      = pg_part_ff[apg];
  assign acc_take = acc_valid && (zst_ff != SMP_ZERO) && !acc_done;
  assign acc_ok   = pg_alloc_ff[apg] && !pg_pend_ff[apg] && pt_own_ff[apt] &&
                    (acc_kind <= SMP_FX) && pt_perm_ff[apt][acc_kind] &&
                    ((pt_owner_ff[apt] == acc_mid) || pt_grp_ff[apt][acc_mid]); // [R8]
  // memory write port, zeroing first
  always_ff @(posedge core_clk)
  begin
    if (zst_ff == SMP_ZERO)
      mem[{zpg_ff, zwd_ff}] <= '0;                                      // [R5] [R6]
    else if (acc_take && acc_ok && (acc_kind == SMP_WR))
      mem[acc_addr] <= acc_wdata;
  end
  // answer; denied reads return zero
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      acc_done  <= 1'b0;
      acc_err   <= 1'b0;
      acc_rdata <= '0;
    end
    else
    begin
      acc_done  <= acc_take;
      acc_err   <= acc_take && !acc_ok;                                 // [R8]
      acc_rdata <= (acc_take && acc_ok && (acc_kind != SMP_WR)) ? mem[acc_addr] : '0;
    end
  end
  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  // helper count of scrub cycles, kept apart from the word counter
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
      zlen_ff <= '0;
    else if (zst_ff == SMP_ZERO)
      zlen_ff <= zlen_ff + 1'b1;
    else
      zlen_ff <= '0;
  end
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);
  claim_owner_a: assert property (cmd_valid && cmd_op == SMP_PERM && // [R1]
    !pt_own_ff[cmd_part] |=> pt_own_ff[$past(cmd_part)] && !cmd_err &&
    pt_owner_ff[$past(cmd_part)] == $past(cmd_mid)) else $error("claim lost");
  page_alloc_a: assert property (do_aloc |=> pg_alloc_ff[$past(cmd_page)] && // [R2]
    pg_part_ff[$past(cmd_page)] == $past(cmd_part)) else $error("page not claimed");
  part_rel_owner_a: assert property (cmd_valid && cmd_op == SMP_RPT && // [R3]
    !is_owner |=> cmd_err) else $error("foreign release taken");
  psp_part_keep_a: assert property (cmd_valid && cmd_op == SMP_RPT && // [R4]
    pt_perm_ff[cmd_part][`SMP_P_PSP] |=> pt_own_ff[$past(cmd_part)] && cmd_err)
    else $error("public partition released");
  viol_zero_a: assert property (viol_rise |=> // [R5]
    (($past(pg_alloc_ff) & $past(pg_csp)) & ~pg_pend_ff) == '0)
    else $error("violation not scrubbed");
  csp_free_a: assert property (|(~pg_alloc_ff & $past(pg_alloc_ff) & // [R6]
    ($past(pg_pend_ff) | $past(pg_csp))) |-> $past(zst_ff == SMP_DONE))
    else $error("critical page unscrubbed");
  page_scrub_a: assert property (do_rpg && pg_csp[cmd_page] |=> // [R7]
    pg_pend_ff[$past(cmd_page)] && pg_alloc_ff[$past(cmd_page)])
    else $error("page freed before zeroing");
  acc_deny_a: assert property (acc_take && !acc_ok |=> acc_done && acc_err && // [R8]
    acc_rdata == '0) else $error("access not refused");
  grp_owner_a: assert property (cmd_valid && cmd_op == SMP_GRP && cmd_part == '0 // [R9]
    && !is_owner |=> $stable(pt_grp_ff[0])) else $error("group changed by stranger");
  psp_page_a: assert property (cmd_valid && cmd_op == SMP_RPG && // [R10]
    pt_perm_ff[cpg_pt][`SMP_P_PSP] |=> cmd_err) else $error("public page released");
  zero_len_a: assert property (zst_ff == SMP_DONE |-> // [R11]
    $past(zst_ff == SMP_ZERO) && zlen_ff == `SMP_ZLEN) else $error("scrub length wrong");
  zero_cap_a: assert property (zlen_ff <= `SMP_ZLEN) else $error("scrub overran"); // [R5]
  viol_c:  cover property (viol_rise ##[1:40] zst_ff == SMP_DONE);
  relpt_c: cover property (do_rpt && |pg_csp);
  deny_c:  cover property (acc_take && !acc_ok);
endmodule // smp_ctrl

// File: testbench/smp_master.sv
// Purpose: bus-master model issuing commands and memory accesses
// Assumes: requests change at the falling edge, answers are read there
// Notes:   released fields are inverted so a stale value never looks live
`timescale 1ns/1ps
`include "smp_defines.svh"
module smp_master (
  input  wire logic               core_clk,
  output logic                    cmd_valid,
  output smp_pkg::smp_op_e        cmd_op,
  output smp_pkg::smp_mid_t       cmd_mid,
  output smp_pkg::smp_pt_t        cmd_part,
  output smp_pkg::smp_pg_t        cmd_page,
  output logic [`SMP_GRPW-1:0]    cmd_data,
  input  wire logic               cmd_done,
  input  wire logic               cmd_err,
  output logic                    acc_valid,
  output smp_pkg::smp_kind_e      acc_kind,
  output smp_pkg::smp_mid_t       acc_mid,
  output smp_pkg::smp_addr_t      acc_addr,
  output logic [`SMP_DW-1:0]      acc_wdata,
  input  wire logic               acc_done,
  input  wire logic               acc_err,
  input  wire logic [`SMP_DW-1:0] acc_rdata
);
  import smp_pkg::*;
  // ---------------------------------------------------------------
  // idle bus at time zero
  // ---------------------------------------------------------------
  initial
  begin
    {cmd_valid, cmd_mid, cmd_part, cmd_page, cmd_data} = '0;
    {acc_valid, acc_mid, acc_addr, acc_wdata} = '0;
    cmd_op   = SMP_PERM;
    acc_kind = SMP_RD;
  end
  // one command cycle; a missing answer comes back unknown
  task automatic cmd(input smp_op_e op, input smp_mid_t mid, input smp_pt_t pt,
                     input smp_pg_t pg, input logic [15:0] dat, output logic err);
    @(negedge core_clk);
    cmd_op = op;
    {cmd_valid, cmd_mid, cmd_part, cmd_page, cmd_data} = {1'b1, mid, pt, pg, dat};
    @(negedge core_clk);
    {cmd_valid, cmd_mid, cmd_part, cmd_page, cmd_data} = {1'b0, ~mid, ~pt, ~pg, ~dat};
    err = (cmd_done === 1'b1) ? cmd_err : 1'bx;
  endtask
  // access held until done, bounded wait covers zeroing stalls
  task automatic acc(input smp_kind_e k, input smp_mid_t mid, input smp_addr_t a,
                     input logic [31:0] wd, output logic err, output logic [31:0] rd);
    int n;
    @(negedge core_clk);
    acc_kind = k;
    {acc_valid, acc_mid, acc_addr, acc_wdata} = {1'b1, mid, a, wd};
    @(negedge core_clk);
    n = 0;
    while (acc_done !== 1'b1 && n < 60)
    begin
      @(negedge core_clk);
      n++;
    end
    err = (acc_done === 1'b1) ? acc_err : 1'bx;
    rd  = acc_rdata;
    {acc_valid, acc_mid, acc_addr, acc_wdata} = {1'b0, ~mid, ~a, ~wd};
  endtask
endmodule // smp_master

// File: testbench/smp_ctrl_tb.sv
// Purpose: self-checking bench for the secure_ram partition controller
// Assumes: inputs change at the falling edge, 50 MHz clock
// Notes:   memory is not reset, so every granted read follows a write
`timescale 1ns/1ps
`include "smp_defines.svh"
module smp_ctrl_tb;
  import smp_pkg::*;
  logic core_clk, rst, violation_in, cmd_valid, cmd_done, cmd_err;
  logic acc_valid, acc_done, acc_err, zero_busy;
  smp_op_e cmd_op;
  smp_kind_e acc_kind;
  smp_mid_t cmd_mid, acc_mid;
  smp_pt_t cmd_part;
  smp_pg_t cmd_page;
  smp_addr_t acc_addr;
  logic [`SMP_GRPW-1:0] cmd_data;
  logic [`SMP_DW-1:0] acc_wdata, acc_rdata;
  int failures = 0;
  int comparisons = 0;
  smp_ctrl uut (.core_clk(core_clk), .rst(rst), .violation_in(violation_in),
    .cmd_valid(cmd_valid), .cmd_op(cmd_op), .cmd_mid(cmd_mid), .cmd_part(cmd_part),
    .cmd_page(cmd_page), .cmd_data(cmd_data), .cmd_done(cmd_done), .cmd_err(cmd_err),
    .acc_valid(acc_valid), .acc_kind(acc_kind), .acc_mid(acc_mid), .acc_addr(acc_addr),
    .acc_wdata(acc_wdata), .acc_done(acc_done), .acc_err(acc_err),
    .acc_rdata(acc_rdata), .zero_busy(zero_busy));
  smp_master pm (.core_clk(core_clk), .cmd_valid(cmd_valid), .cmd_op(cmd_op),
    .cmd_mid(cmd_mid), .cmd_part(cmd_part), .cmd_page(cmd_page), .cmd_data(cmd_data),
    .cmd_done(cmd_done), .cmd_err(cmd_err), .acc_valid(acc_valid), .acc_kind(acc_kind),
    .acc_mid(acc_mid), .acc_addr(acc_addr), .acc_wdata(acc_wdata),
    .acc_done(acc_done), .acc_err(acc_err), .acc_rdata(acc_rdata));
  // ---------------------------------------------------------------
  // clock and shared checks
  // ---------------------------------------------------------------
  initial
  begin
    core_clk = 1'b0;
    forever #10 core_clk = ~core_clk;
  end
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp)
    begin
      failures++;
      $display("wrong value %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // command with expected refusal flag
  task automatic c(input smp_op_e op, input smp_mid_t m, input smp_pt_t pt, input smp_pg_t pg,
                   input logic [15:0] d, input logic ee, input string nm);
    logic e;
    pm.cmd(op, m, pt, pg, d, e);
    chk(nm, {31'h0, ee}, {31'h0, e});
  endtask
  // access with expected refusal flag and read data
  task automatic a(input smp_kind_e k, input smp_mid_t m, input smp_addr_t ad,
                   input logic [31:0] wd, input logic ee, input logic [31:0] er, input string nm);
    logic e;
    logic [31:0] r;
    pm.acc(k, m, ad, wd, e, r);
    chk(nm, {31'h0, ee}, {31'h0, e});
    chk(nm, er, r);
  endtask
  // zeroizer must be busy, then finish within a bounded time
  task automatic wait_zero;
    int n;
    repeat (6) @(negedge core_clk);
    chk("zero_busy high", 32'h1, {31'h0, zero_busy});
    n = 0;
    while (zero_busy !== 1'b0 && n < 300)
    begin
      @(negedge core_clk);
      n++;
    end
    chk("zero_busy low", 32'h0, {31'h0, zero_busy});
  endtask
  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  task automatic t_claim;
    c(SMP_PERM, 4'h3, 2'h0, 3'h0, 16'h0007, 1'b0, "claim");
    c(SMP_PERM, 4'h5, 2'h0, 3'h0, 16'h0007, 1'b1, "perm by other");
    c(SMP_GRP, 4'h5, 2'h0, 3'h0, 16'hFFFF, 1'b1, "group by other");
    c(SMP_ALOC, 4'h3, 2'h0, 3'h1, 16'h0000, 1'b0, "alloc");
    c(SMP_ALOC, 4'h3, 2'h0, 3'h1, 16'h0000, 1'b1, "alloc taken");
    c(SMP_ALOC, 4'h5, 2'h0, 3'h2, 16'h0000, 1'b1, "alloc non-owner");
  endtask
  task automatic t_access;
    a(SMP_WR, 4'h3, 7'h12, 32'hA5A50001, 1'b0, 32'h0, "owner write");
    a(SMP_RD, 4'h3, 7'h12, 32'h0, 1'b0, 32'hA5A50001, "owner read");
    a(SMP_RD, 4'h5, 7'h12, 32'h0, 1'b1, 32'h0, "other read");
    a(SMP_RD, 4'h3, 7'h22, 32'h0, 1'b1, 32'h0, "free page read");
    c(SMP_GRP, 4'h3, 2'h0, 3'h0, 16'h0020, 1'b0, "group set");
    a(SMP_RD, 4'h5, 7'h12, 32'h0, 1'b0, 32'hA5A50001, "group read");
    c(SMP_PERM, 4'h3, 2'h0, 3'h0, 16'h0005, 1'b0, "perm rx");
    a(SMP_WR, 4'h3, 7'h12, 32'h1, 1'b1, 32'h0, "write denied");
    a(SMP_FX, 4'h5, 7'h12, 32'h0, 1'b0, 32'hA5A50001, "group fetch");
  endtask
  task automatic t_public;
    c(SMP_PERM, 4'h4, 2'h1, 3'h0, 16'h0017, 1'b0, "public claim");
    c(SMP_ALOC, 4'h4, 2'h1, 3'h2, 16'h0000, 1'b0, "public alloc");
    c(SMP_RPG, 4'h4, 2'h1, 3'h2, 16'h0000, 1'b1, "public page release");
    c(SMP_RPT, 4'h4, 2'h1, 3'h0, 16'h0000, 1'b1, "public part release");
    a(SMP_WR, 4'h4, 7'h20, 32'h00000B0B, 1'b0, 32'h0, "public still held");
    a(SMP_RD, 4'h4, 7'h20, 32'h0, 1'b0, 32'h00000B0B, "public data");
  endtask
  task automatic t_crit;
    c(SMP_PERM, 4'h6, 2'h2, 3'h0, 16'h000F, 1'b0, "crit claim");
    c(SMP_ALOC, 4'h6, 2'h2, 3'h3, 16'h0000, 1'b0, "crit alloc");
    a(SMP_WR, 4'h6, 7'h31, 32'hDEADBEEF, 1'b0, 32'h0, "crit write");
    c(SMP_RPG, 4'h6, 2'h2, 3'h3, 16'h0000, 1'b0, "crit page release");
    c(SMP_ALOC, 4'h6, 2'h2, 3'h3, 16'h0000, 1'b1, "page pending");
    wait_zero();
    c(SMP_ALOC, 4'h6, 2'h2, 3'h3, 16'h0000, 1'b0, "realloc");
    a(SMP_RD, 4'h6, 7'h31, 32'h0, 1'b0, 32'h0, "page zeroed");
    a(SMP_WR, 4'h6, 7'h35, 32'h12345678, 1'b0, 32'h0, "crit write 2");
    c(SMP_RPT, 4'h4, 2'h2, 3'h0, 16'h0000, 1'b1, "release by other");
    c(SMP_RPT, 4'h6, 2'h2, 3'h0, 16'h0000, 1'b0, "part release");
    c(SMP_PERM, 4'h7, 2'h2, 3'h0, 16'h000F, 1'b0, "reclaim");
    c(SMP_ALOC, 4'h7, 2'h2, 3'h3, 16'h0000, 1'b1, "part page pending");
    wait_zero();
    c(SMP_ALOC, 4'h7, 2'h2, 3'h3, 16'h0000, 1'b0, "pool return");
    a(SMP_RD, 4'h7, 7'h35, 32'h0, 1'b0, 32'h0, "part zeroed");
  endtask
  task automatic t_violation;
    a(SMP_WR, 4'h7, 7'h3A, 32'h0000CAFE, 1'b0, 32'h0, "crit write 3");
    @(negedge core_clk);
    violation_in = 1'b1;
    wait_zero();
    violation_in = 1'b0;
    a(SMP_RD, 4'h7, 7'h3A, 32'h0, 1'b0, 32'h0, "crit wiped");
    a(SMP_RD, 4'h3, 7'h12, 32'h0, 1'b0, 32'hA5A50001, "plain kept");
  endtask
  // ---------------------------------------------------------------
  // closing, watchdog and main sequence
  // ---------------------------------------------------------------
  task automatic print_verdict;
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  // about 150 cycles expected, limit well beyond
  initial
  begin
    #200000;
    failures++;
    print_verdict();
  end
  initial
  begin
    rst = 1'b1;
    violation_in = 1'b0;
    repeat (3) @(negedge core_clk);
    rst = 1'b0;
    chk("idle busy", 32'h0, {31'h0, zero_busy});
    t_claim();
    t_access();
    t_public();
    t_crit();
    t_violation();
    print_verdict();
  end
endmodule // smp_ctrl_tb
